// file: inc/cst_pkg.sv
// Constants and carrier types for the synchronous transfer interrupt block.
// Assumes a frame data clock of two data clocks per bit clock, eight bits per slot.
package cst_pkg;

   // ********************************************************
   // Geometry
   // ********************************************************
   localparam int NCH           = 4;
   localparam int TS_W          = 5;
   localparam int FRAME_SLOTS   = 32;
   localparam int BITS_PER_SLOT = 8;
   localparam int DCL_PER_BCL   = 2;
   localparam int DCL_PER_SLOT  = BITS_PER_SLOT * DCL_PER_BCL;
   localparam int POS_W         = 10;

   // ********************************************************
   // Timing in bit clocks, and derived data clock counts
   // ********************************************************
   localparam int LEAD_BCL_DPS0 = 2;
   localparam int LEAD_BCL_DPS1 = 1;
   localparam int LEAD_DCL_DPS0 = LEAD_BCL_DPS0 * DCL_PER_BCL;
   localparam int LEAD_DCL_DPS1 = LEAD_BCL_DPS1 * DCL_PER_BCL;

   // ********************************************************
   // Reset values
   // ********************************************************
   localparam logic [NCH-1:0]   FLAGS_RST = 4'h0;
   localparam logic [POS_W-1:0] POS_RST   = 10'h000;

   // Per channel slot and data port choice
   typedef struct packed {
      logic            port_select;
      logic [TS_W-1:0] timeslot_select;
   } cst_slot_cfg_t;

   // Enables and masks, a set mask bit disables
   typedef struct packed {
      logic [NCH-1:0] input_en;
      logic [NCH-1:0] output_en;
      logic [NCH-1:0] transfer_irq_mask;
      logic [NCH-1:0] overflow_irq_mask;
   } cst_ctl_t;

endpackage

// file: tb/cst_link_model.sv
// Link side model: free running data clock, frame sync, frame position.
// Assumes the bench gives the same FRAME_SLOTS as the design.
`timescale 1ns/100ps
`default_nettype none

module cst_link_model #(
   parameter int FRAME_SLOTS = 12
) (
   // Link pins
   output var logic       dcl_o,
   output var logic       fsc_o,
   // Data clock count since frame start
   output var logic [9:0] pos_o
);
   // ****************
   // Clock and sync
   // ****************
   // Start late in a frame so the first sync edge comes after reset
   initial
   begin
      dcl_o = 1'b0;
      fsc_o = 1'b0;
      pos_o = 10'h064;
      #3.3;
      forever
         #7.5 dcl_o = ~dcl_o;
   end

   // Moved on the falling edge, away from where the design samples
   always @(negedge dcl_o)
   begin
      pos_o <= (pos_o == 10'(FRAME_SLOTS * 16 - 1)) ? 10'h000 : pos_o + 10'h001;
      fsc_o <= (pos_o == 10'(FRAME_SLOTS * 16 - 1)) || (pos_o < 10'h00F);
   end
endmodule // cst_link_model
`default_nettype wire

// file: tb/cst_sync_irq_asserts.sv
// Checker for the transfer interrupt block, system clock domain.
// Assumes it is bound to cst_sync_irq with the same FRAME_SLOTS.
`timescale 1ns/100ps
`default_nettype none

module cst_sync_irq_asserts #(
   parameter int FRAME_SLOTS = 32
) (
   // Clock and reset
   input wire logic                        sys_clk_i,
   input wire logic                        resetn_i,
   // Link, configuration and host pulses
   input wire logic                        frame_data_clock_i,
   input wire logic                        frame_sync_i,
   input wire cst_pkg::cst_slot_cfg_t [3:0] channel_slot_port_config_i,
   input wire cst_pkg::cst_ctl_t           ctl_i,
   input wire logic [3:0]                  channel_ack_bit_i,
   input wire logic [3:0]                  overflow_clr_i,
   // Status
   input wire logic [3:0]                  channel_transfer_ready_irq_o,
   input wire logic [3:0]                  channel_transfer_overflow_irq_o,
   input wire logic                        irq_o
);
   // ****************
   // History
   // ****************
   logic [3:0]        tr, ov, tr_q, ov_q, clr_q;
   cst_pkg::cst_ctl_t ctl_q;
   assign tr = channel_transfer_ready_irq_o;
   assign ov = channel_transfer_overflow_irq_o;

   // One cycle back, so a flag change meets the inputs that caused it
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         tr_q  <= 4'h0;
         ov_q  <= 4'h0;
         clr_q <= 4'h0;
         ctl_q <= 16'h0000;
      end
      else
      begin
         tr_q  <= tr;
         ov_q  <= ov;
         clr_q <= overflow_clr_i;
         ctl_q <= ctl_i;
      end
   end

   // ****************
   // Properties
   // ****************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!resetn_i);
   property p_or; irq_o == |{tr, ov}; endproperty
   a_or: assert property (p_or) else $error("irq_o differs from flags");
   property p_rel; $rose(resetn_i) |-> {tr, ov, irq_o} == 9'h000; endproperty
   a_rel: assert property (p_rel) else $error("flags set at reset release");
   property p_trsrc; (tr & ~tr_q & ~(ctl_q.input_en & ~ctl_q.transfer_irq_mask)) == 4'h0;
   endproperty
   a_trsrc: assert property (p_trsrc) else $error("ready set while disabled");
   property p_ovsrc; (ov & ~ov_q & ~(ctl_q.output_en & ~ctl_q.overflow_irq_mask)) == 4'h0;
   endproperty
   a_ovsrc: assert property (p_ovsrc) else $error("overflow set while disabled");
   property p_cause; (ov & ~ov_q) != 4'h0 |-> (tr_q & ~tr) != 4'h0; endproperty
   a_cause: assert property (p_cause) else $error("overflow without missed ready");
   property p_none; ctl_q.transfer_irq_mask == 4'hF |-> (ov & ~ov_q) == 4'h0; endproperty
   a_none: assert property (p_none) else $error("overflow with all ready masked");
   property p_ack; (channel_ack_bit_i & tr) != 4'h0 |=> (tr & $past(channel_ack_bit_i)) == 4'h0;
   endproperty
   a_ack: assert property (p_ack) else $error("ready kept after ack");
   property p_stick; (ov_q & ~ov & ~clr_q) == 4'h0; endproperty
   a_stick: assert property (p_stick) else $error("overflow dropped uncleared");
   property p_clr; (overflow_clr_i & ov) != 4'h0 |=> (ov & $past(overflow_clr_i)) == 4'h0;
   endproperty
   a_clr: assert property (p_clr) else $error("overflow kept after clear");
   c_tr: cover property ((tr & ~tr_q) != 4'h0);
   c_ov: cover property ((ov & ~ov_q) != 4'h0);
   c_ack: cover property ((channel_ack_bit_i & tr) != 4'h0);
endmodule // cst_sync_irq_asserts
`default_nettype wire

// file: tb/cst_sync_irq_test.sv
// Self-checking bench for the transfer interrupt block.
// Assumes the link model and the checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
   begin \
      n_compared++; \
      if ((a) !== (b)) \
      begin \
         err_total++; \
         $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
      end \
   end

module cst_sync_irq_test;
   // ****************
   // Signals
   // ****************
   localparam int FS = 12;
   localparam int F  = FS * 16;
   logic                         sys_clk_i = 1'b0;
   logic                         resetn_i  = 1'b0;
   logic                         frame_data_clock, fsc, irq;
   logic [9:0]                   pos;
   cst_pkg::cst_slot_cfg_t [3:0] cfg = {6'h2B, 6'h03, 6'h22, 6'h02};
   cst_pkg::cst_ctl_t            ctl = 16'h0000;
   logic [3:0]                   ack = 4'h0, clr = 4'h0, got = 4'h0, tr_q = 4'h0;
   logic [3:0]                   tr, ov;
   logic                         auto_ack = 1'b0;
   int                           rise [4];
   int                           cyc, err_total, n_compared;

   cst_link_model #(.FRAME_SLOTS(FS)) cst_link_model_i (.dcl_o(frame_data_clock), .fsc_o(fsc), .pos_o(pos));

   cst_sync_irq #(.FRAME_SLOTS(FS)) cst_sync_irq_i (
      .sys_clk_i                      (sys_clk_i),
      .resetn_i                       (resetn_i),
      .frame_data_clock_i             (frame_data_clock),
      .frame_sync_i                   (fsc),
      .channel_slot_port_config_i     (cfg),
      .ctl_i                          (ctl),
      .channel_ack_bit_i              (ack),
      .overflow_clr_i                 (clr),
      .channel_transfer_ready_irq_o   (tr),
      .channel_transfer_overflow_irq_o(ov),
      .irq_o                          (irq)
   );

   // Clock, host auto acknowledge long before each deadline, rise monitor
   initial
      forever
         #2 sys_clk_i = ~sys_clk_i;
   always @(posedge sys_clk_i)
   begin
      ack <= auto_ack ? (tr & ~ack) : 4'h0;
      for (int c = 0; c < 4; c++)
         if (tr[c] === 1'b1 && tr_q[c] === 1'b0)
         begin
            rise[c] = pos;
            got[c]  = 1'b1;
         end
      tr_q <= tr;
      cyc++;
      if (cyc == 40000)
      begin
         err_total++;
         conclude();
      end
   end

   // ****************
   // Scenarios
   // ****************
   function automatic int t_exp(int c);
      return ((cfg[c].timeslot_select + 1) * 16 + (cfg[c].port_select ? 2 : 4)) % F;
   endfunction

   task automatic wait_pos();
      for (int i = 0; i < 800 && pos !== 10'h014; i++)
         @(posedge sys_clk_i);
   endtask

   // Ready points relative to channel 0; jitter of one data clock allowed
   task automatic t_timing();
      int b, d;
      ctl <= 16'hFF00;
      auto_ack <= 1'b1;
      wait_pos();
      got = 4'h0;
      for (int i = 0; i < 2000 && got !== 4'hF; i++)
         @(posedge sys_clk_i);
      b = rise[0] - t_exp(0);
      for (int c = 1; c < 4; c++)
      begin
         d = rise[c] - t_exp(c) - b;
         `CHK(((d + 2 * F + 1) % F) <= 2, 1'b1)
      end
      `CHK(ov, 4'h0)
   endtask

   task automatic t_hold();
      auto_ack <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      for (int i = 0; i < 800 && tr[0] !== 1'b1; i++)
         @(posedge sys_clk_i);
      ctl.input_en <= 4'hE;
      repeat (4) @(posedge sys_clk_i);
      `CHK(tr[0], 1'b1)
      `CHK(irq, 1'b1)
   endtask

   // Each entry: auto ack, expected overflows, control word
   task automatic t_route();
      logic [20:0] tbl [10] = '{21'h00FFEF, 21'h00FFFE, 21'h02FFED, 21'h03FFEC, 21'h03FFCC,
                                21'h02FFCD, 21'h07FFC8, 21'h10FFC8, 21'h00EFEE, 21'h00FDED};
      logic [3:0]  seen;
      for (int e = 0; e < 10; e++)
      begin
         ctl <= tbl[e][15:0];
         auto_ack <= tbl[e][20];
         repeat (800) @(posedge sys_clk_i);
         wait_pos();
         clr <= 4'hF;
         @(posedge sys_clk_i);
         clr <= 4'h0;
         seen = 4'h0;
         repeat (730)
         begin
            @(posedge sys_clk_i);
            seen = seen | tr;
         end
         `CHK(ov, tbl[e][19:16])
         `CHK(seen, ctl.input_en & ~ctl.transfer_irq_mask)
      end
   endtask

   task automatic conclude();
      if (err_total == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Reset stretched to cover three link clock edges
   initial
   begin
      repeat (14) @(posedge sys_clk_i);
      resetn_i <= 1'b1;
      repeat (4) @(posedge sys_clk_i);
      `CHK({tr, ov, irq}, 9'h000)
      t_timing();
      t_hold();
      t_route();
      conclude();
   end
endmodule // cst_sync_irq_test

bind cst_sync_irq cst_sync_irq_asserts #(.FRAME_SLOTS(FRAME_SLOTS)) cst_sync_irq_asserts_i (
   .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .frame_data_clock_i(frame_data_clock_i),
   .frame_sync_i(frame_sync_i), .channel_slot_port_config_i(channel_slot_port_config_i),
   .ctl_i(ctl_i), .channel_ack_bit_i(channel_ack_bit_i), .overflow_clr_i(overflow_clr_i),
   .channel_transfer_ready_irq_o(channel_transfer_ready_irq_o),
   .channel_transfer_overflow_irq_o(channel_transfer_overflow_irq_o), .irq_o(irq_o));
`default_nettype wire

// file: verilog/cst_evt_sync.sv
// Toggle based event crossing from one clock domain to another.
// Assumes source events are at least one source clock apart and the
// destination clock is fast enough to see every toggle twice.
`timescale 1ns/100ps
`default_nettype none

module cst_evt_sync #(
   parameter int W = 4
) (
   // Source side
   input  wire logic         src_clk_i,
   input  wire logic         src_resetn_i,
   input  wire logic [W-1:0] src_pulse_i,
   // Destination side
   input  wire logic         dst_clk_i,
   input  wire logic         dst_resetn_i,
   output logic      [W-1:0] dst_pulse_o
);

   logic [W-1:0] tgl_r;
   logic [W-1:0] tgl_nxt;
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;
   logic [W-1:0] prev_r;
   logic [W-1:0] pulse_r;
   logic [W-1:0] pulse_nxt;

   // Each event flips its toggle
   always_comb
   begin
      tgl_nxt = tgl_r ^ src_pulse_i;
   end

   always_ff @(posedge src_clk_i or negedge src_resetn_i)
   begin
      if (!src_resetn_i)
         tgl_r <= '0;
      else
         tgl_r <= tgl_nxt;
   end

   // Edge seen only past the second stage
   always_comb
   begin
      pulse_nxt = sync_r ^ prev_r;
   end

   always_ff @(posedge dst_clk_i or negedge dst_resetn_i)
   begin
      if (!dst_resetn_i)
      begin
         meta_r  <= '0;
         sync_r  <= '0;
         prev_r  <= '0;
         pulse_r <= '0;
      end
      else
      begin
         meta_r  <= tgl_r;
         sync_r  <= meta_r;
         prev_r  <= sync_r;
         pulse_r <= pulse_nxt;
      end
   end

   assign dst_pulse_o = pulse_r;

endmodule // cst_evt_sync

`default_nettype wire

// file: verilog/cst_sync_irq.sv
// Transfer-ready and overflow interrupt generation for four channels.
// Assumes the frame data clock and frame sync arrive from the link, and the
// host side control ports are static or on sys_clk_i.
`timescale 1ns/100ps
`default_nettype none

module cst_sync_irq #(
   parameter int FRAME_SLOTS = cst_pkg::FRAME_SLOTS
) (
   // System clock and reset
   input  wire logic                                 sys_clk_i,
   input  wire logic                                 resetn_i,
   // Link side
   input  wire logic                                 frame_data_clock_i,
   input  wire logic                                 frame_sync_i,
   // Channel configuration
   input  wire cst_pkg::cst_slot_cfg_t [cst_pkg::NCH-1:0] channel_slot_port_config_i,
   input  wire cst_pkg::cst_ctl_t                    ctl_i,
   // Host acknowledge and clear pulses
   input  wire logic [cst_pkg::NCH-1:0]              channel_ack_bit_i,
   input  wire logic [cst_pkg::NCH-1:0]              overflow_clr_i,
   // Status
   output logic      [cst_pkg::NCH-1:0]              channel_transfer_ready_irq_o,
   output logic      [cst_pkg::NCH-1:0]              channel_transfer_overflow_irq_o,
   output logic                                      irq_o
);

   localparam int NCH       = cst_pkg::NCH;
   localparam int POS_W     = cst_pkg::POS_W;
   localparam int FRAME_DCL = FRAME_SLOTS * cst_pkg::DCL_PER_SLOT;
   localparam int CFG_W     = $bits(cst_pkg::cst_slot_cfg_t) * NCH;

   // ********************************************************
   // Slot point function
   // ********************************************************

   // Frame position of the ready or the deadline point of one channel
   function automatic logic [POS_W-1:0] slot_point(
      input cst_pkg::cst_slot_cfg_t cfg,
      input logic                   ready
   );
      int lead;
      int v;
      begin
         lead = cfg.port_select ? cst_pkg::LEAD_DCL_DPS1
                                : cst_pkg::LEAD_DCL_DPS0;
         if (ready)
            v = (int'(cfg.timeslot_select) + 1) * cst_pkg::DCL_PER_SLOT + lead;
         else
            v = int'(cfg.timeslot_select) * cst_pkg::DCL_PER_SLOT
                + FRAME_DCL - lead;
         v = v % FRAME_DCL;
         slot_point = POS_W'(v);
      end
   endfunction

   // ********************************************************
   // Link domain reset
   // ********************************************************

   logic lrst_meta_r;
   logic lrst_sync_r;

   // Release synchronised to the link clock, assertion immediate
   always_ff @(posedge frame_data_clock_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         lrst_meta_r <= 1'b0;
         lrst_sync_r <= 1'b0;
      end
      else
      begin
         lrst_meta_r <= 1'b1;
         lrst_sync_r <= lrst_meta_r;
      end
   end

   // ********************************************************
   // Link domain input capture
   // ********************************************************

   logic             fs_meta_r;
   logic             fs_sync_r;
   logic             fs_prev_r;
   logic [CFG_W-1:0] cfg_meta_r;
   logic [CFG_W-1:0] cfg_sync_r;
   cst_pkg::cst_slot_cfg_t [NCH-1:0] lcfg;

   // Two stages for the pin and for the quasi static config
   always_ff @(posedge frame_data_clock_i or negedge lrst_sync_r)
   begin
      if (!lrst_sync_r)
      begin
         fs_meta_r  <= 1'b0;
         fs_sync_r  <= 1'b0;
         fs_prev_r  <= 1'b0;
         cfg_meta_r <= '0;
         cfg_sync_r <= '0;
      end
      else
      begin
         fs_meta_r  <= frame_sync_i;
         fs_sync_r  <= fs_meta_r;
         fs_prev_r  <= fs_sync_r;
         cfg_meta_r <= channel_slot_port_config_i;
         cfg_sync_r <= cfg_meta_r;
      end
   end

   // Config changes are expected only while the channel is idle;
   // a mid-frame change may misplace one point, never hang a channel
   assign lcfg = cfg_sync_r;

   // ********************************************************
   // Link domain frame position
   // ********************************************************

   logic [POS_W-1:0] pos_r;
   logic [POS_W-1:0] pos_nxt;
   logic             fs_rise;

   // Sync edge taken past the second stage only
   assign fs_rise = fs_sync_r & ~fs_prev_r;

   // Data clock count inside the frame, restarted by sync
   always_comb
   begin
      pos_nxt = pos_r + POS_W'(1);
      if (fs_rise)
         pos_nxt = POS_W'(1);
      else if (pos_r == POS_W'(FRAME_DCL - 1))
         pos_nxt = cst_pkg::POS_RST;
   end

   // Position register, free running between syncs
   always_ff @(posedge frame_data_clock_i or negedge lrst_sync_r)
   begin
      if (!lrst_sync_r)
         pos_r <= cst_pkg::POS_RST;
      else
         pos_r <= pos_nxt;
   end

   // ********************************************************
   // Link domain event points
   // ********************************************************

   logic [NCH-1:0] rdy_hit;
   logic [NCH-1:0] dl_hit;

   // Points fire every frame, host action does not stop them
   generate
      for (genvar c = 0; c < NCH; c++)
      begin : g_points
         assign rdy_hit[c] = (pos_r == slot_point(lcfg[c], 1'b1));
         assign dl_hit[c]  = (pos_r == slot_point(lcfg[c], 1'b0));
      end
   endgenerate

   // ********************************************************
   // Crossing to the system clock
   // ********************************************************

   logic           srst_meta_r;
   logic           srst_sync_r;
   logic [NCH-1:0] rdy_evt;
   logic [NCH-1:0] dl_evt;

   // Release synchronised to the system clock, flags stay clear two more edges
   always_ff @(posedge sys_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         srst_meta_r <= 1'b0;
         srst_sync_r <= 1'b0;
      end
      else
      begin
         srst_meta_r <= 1'b1;
         srst_sync_r <= srst_meta_r;
      end
   end

   // Ready points
   cst_evt_sync #(
      .W            (NCH)
   ) u_rdy_sync (
      .src_clk_i    (frame_data_clock_i),
      .src_resetn_i (lrst_sync_r),
      .src_pulse_i  (rdy_hit),
      .dst_clk_i    (sys_clk_i),
      .dst_resetn_i (srst_sync_r),
      .dst_pulse_o  (rdy_evt)
   );

   // Deadline points
   cst_evt_sync #(
      .W            (NCH)
   ) u_dl_sync (
      .src_clk_i    (frame_data_clock_i),
      .src_resetn_i (lrst_sync_r),
      .src_pulse_i  (dl_hit),
      .dst_clk_i    (sys_clk_i),
      .dst_resetn_i (srst_sync_r),
      .dst_pulse_o  (dl_evt)
   );

   // ********************************************************
   // Transfer-ready flags
   // ********************************************************

   logic [NCH-1:0] sti_r;
   logic [NCH-1:0] sti_nxt;
   logic [NCH-1:0] sti_set;

   // Only an unmasked channel with its input enabled raises
   assign sti_set = rdy_evt & ctl_i.input_en & ~ctl_i.transfer_irq_mask;

   // Clear by ack or deadline, a new ready wins over both
   always_comb
   begin
      sti_nxt = sti_r;
      sti_nxt = sti_nxt & ~channel_ack_bit_i;
      sti_nxt = sti_nxt & ~dl_evt;
      sti_nxt = sti_nxt | sti_set;
   end

   // Pending ready flags
   always_ff @(posedge sys_clk_i or negedge srst_sync_r)
   begin
      if (!srst_sync_r)
         sti_r <= cst_pkg::FLAGS_RST;
      else
         sti_r <= sti_nxt;
   end

   // ********************************************************
   // Overflow stimulus and routing
   // ********************************************************

   logic [NCH-1:0] stim;
   logic [NCH-1:0] ov_set;

   // A missed transfer-ready: still pending at its deadline
   always_comb
   begin
      stim = dl_evt & sti_r & ~channel_ack_bit_i
             & ~ctl_i.transfer_irq_mask;
   end

   // Own stimulus always, any stimulus when own ready is masked
   generate
      for (genvar k = 0; k < NCH; k++)
      begin : g_route
         assign ov_set[k] = ctl_i.output_en[k]
                            & ~ctl_i.overflow_irq_mask[k]
                            & (stim[k]
                               | (ctl_i.transfer_irq_mask[k] & (|stim)));
      end
   endgenerate

   // ********************************************************
   // Overflow flags and summary
   // ********************************************************

   logic [NCH-1:0] transfer_overflow_irq_r;
   logic [NCH-1:0] transfer_overflow_irq_nxt;
   logic           irq_r;
   logic           irq_nxt;

   // Sticky until host clear, a set in the same cycle wins
   always_comb
   begin
      transfer_overflow_irq_nxt = (transfer_overflow_irq_r & ~overflow_clr_i) | ov_set;
      irq_nxt  = (|sti_nxt) | (|transfer_overflow_irq_nxt);
   end

   // Overflow flags and summary, summary tracks the flags in the same cycle
   always_ff @(posedge sys_clk_i or negedge srst_sync_r)
   begin
      if (!srst_sync_r)
      begin
         transfer_overflow_irq_r <= cst_pkg::FLAGS_RST;
         irq_r  <= 1'b0;
      end
      else
      begin
         transfer_overflow_irq_r <= transfer_overflow_irq_nxt;
         irq_r  <= irq_nxt;
      end
   end

   // ********************************************************
   // Outputs
   // ********************************************************

   // Straight from the flags, no gate between flop and pin
   assign channel_transfer_ready_irq_o    = sti_r;
   assign channel_transfer_overflow_irq_o = transfer_overflow_irq_r;
   assign irq_o                           = irq_r;

endmodule // cst_sync_irq

`default_nettype wire
